// ---- scpwm_consts.svh ----
// register indices, field positions and reset values of the pwm unit
// assumes a 32-bit classic wishbone bus; byte address = 4 * index
`ifndef SCPWM_CONSTS_SVH
`define SCPWM_CONSTS_SVH

// ----------------------------------------
// register indices (byte address / 4)
// ----------------------------------------
`define SCPWM_IDX_ROUTE_ALT 8'hc6
`define SCPWM_IDX_ROUTE_PRI 8'hde
`define SCPWM_IDX_CTRL1     8'hdf
`define SCPWM_IDX_DT_EN     8'hf9
`define SCPWM_IDX_DT_CNT    8'hfa
`define SCPWM_IDX_GUARD     8'hc7
`define SCPWM_IDX_PER_L     8'hb0
`define SCPWM_IDX_PER_H     8'hb1
`define SCPWM_IDX_CNT_L     8'hb2
`define SCPWM_IDX_CNT_H     8'hb3
`define SCPWM_IDX_STAT      8'hb4
`define SCPWM_IDX_DUTY_BASE 8'ha0

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define SCPWM_CTRL_TYP_BIT  4
`define SCPWM_CTRL_MODE_LSB 6
`define SCPWM_DTEN_CNT8_BIT 4
`define SCPWM_PRI_MASK      8'h3f
`define SCPWM_ALT_MASK      8'h2e
`define SCPWM_DTEN_MASK     8'h17

// ----------------------------------------
// reset values and unlock keys
// ----------------------------------------
`define SCPWM_RST_BYTE      8'h00
`define SCPWM_KEY_FIRST     8'haa
`define SCPWM_KEY_SECOND    8'h55

`endif

// ---- scpwm_pkg.sv ----
// types shared by the pwm unit modules
// assumes nothing beyond a systemverilog tool
`default_nettype none

package scpwm_pkg;

  // pairing of the odd channel with its even partner
  typedef enum logic [1:0] {
    SCPWM_PAIR_INDEP = 2'b00,
    SCPWM_PAIR_COMP  = 2'b01,
    SCPWM_PAIR_SYNC  = 2'b10,
    SCPWM_PAIR_RSVD  = 2'b11
  } scpwm_pair_t;

  // timed-access unlock progress
  typedef enum logic [1:0] {
    SCPWM_GRD_IDLE = 2'b00,
    SCPWM_GRD_HALF = 2'b01,
    SCPWM_GRD_OPEN = 2'b10
  } scpwm_grd_t;

  // counter configuration carried into the timebase
  typedef struct packed {
    logic       center; // 1 = center-aligned
    logic [2:0] div;    // prescale exponent
  } scpwm_cfg_t;

  // timebase state carried back to the compare stage
  typedef struct packed {
    logic        tick;  // one pwm clock step
    logic        up;    // counting upward
    logic        wrap;  // period boundary this step
    logic [15:0] cnt;   // counter value
  } scpwm_tb_t;

endpackage

`default_nettype wire

// ---- scpwm_timebase.sv ----
// prescaler and shared 16-bit period counter
// assumes cfg and period are stable register outputs
`default_nettype none
`include "scpwm_consts.svh"

module scpwm_timebase (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire scpwm_pkg::scpwm_cfg_t cfg_i,
  input  wire logic [15:0]       period_i,
  output var  scpwm_pkg::scpwm_tb_t  tb_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [6:0]  pre_q, pre_d;   // free prescaler
  logic [15:0] cnt_q, cnt_d;   // period counter
  logic [15:0] per_q, per_d;   // active period
  logic        up_q, up_d;     // direction
  logic        tick;           // pwm clock step
  logic        wrap;           // boundary step
  logic [6:0]  mask;           // prescale mask

  // divide by two to the power of div
  always_comb begin
    mask = 7'((8'h01 << cfg_i.div) - 8'h01);
    tick = (pre_q & mask) == mask;
    pre_d = pre_q + 7'h01;
  end

  // next count, direction and boundary
  always_comb begin
    cnt_d = cnt_q;
    up_d  = up_q;
    per_d = per_q;
    wrap  = 1'b0;
    if (tick) begin
      if (!cfg_i.center) begin
        up_d = 1'b1;
        if (cnt_q >= per_q) begin
          cnt_d = 16'h0000;
          wrap  = 1'b1;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end else if (up_q) begin
        if (cnt_q >= per_q) begin
          up_d  = 1'b0;
          cnt_d = (per_q == 16'h0000) ? 16'h0000 : per_q - 16'h0001;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end else if (cnt_q <= 16'h0001) begin
        cnt_d = 16'h0000;
        up_d  = 1'b1;
        wrap  = 1'b1;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
      // new period only at the boundary
      if (wrap) begin
        per_d = period_i;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 7'h00;
      cnt_q <= 16'h0000;
      per_q <= 16'h0000;
      up_q  <= 1'b1;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      per_q <= per_d;
      up_q  <= up_d;
    end
  end

  assign tb_o = '{tick: tick, up: up_q, wrap: wrap, cnt: cnt_q};

endmodule

`default_nettype wire

// ---- scpwm_deadtime.sv ----
// dead-time stage of one channel pair
// assumes the pair inputs change on pwm ticks only
`default_nettype none
`include "scpwm_consts.svh"

module scpwm_deadtime (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       en_i,
  input  wire logic [8:0] dt_i,
  input  wire logic       a_i,
  input  wire logic       b_i,
  output logic            a_o,
  output logic            b_o
);

  logic [8:0] cnt_q, cnt_d;     // shared down-counter
  logic       pa_q, pb_q;       // previous inputs
  logic       rise;             // either input rose

  // reload on a rising edge, else count down per tick
  always_comb begin
    rise  = (a_i & ~pa_q) | (b_i & ~pb_q);
    cnt_d = cnt_q;
    if (rise) begin
      cnt_d = dt_i;
    end else if (tick_i && cnt_q != 9'h000) begin
      cnt_d = cnt_q - 9'h001;
    end
    // high only once the counter has run out
    a_o = en_i ? (a_i & (cnt_d == 9'h000)) : a_i;
    b_o = en_i ? (b_i & (cnt_d == 9'h000)) : b_i;
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 9'h000;
      pa_q  <= 1'b0;
      pb_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pa_q  <= a_i;
      pb_q  <= b_i;
    end
  end

endmodule

`default_nettype wire

// ---- scpwm_top.sv ----
// six-channel three-pair pwm unit with wishbone registers
// assumes a classic wishbone master on clk_i and a sync reset
//
// Functional notes
// - primary route bit n puts channel n on pin
// - alternate bits 5,3,2,1 route channels to pins
// - control bit 4 picks edge or center form
// - edge form counts zero up to period
// - edge form sets at zero, clears on match
// - edge period is period plus one ticks
// - center form counts up then back down
// - center clears on up match, sets on down
// - center period is twice period ticks
// - mode bits 7:6 pick pairing, 11 reserved
// - independent pairing is reset default
// - complementary odd channel inverts even partner
// - pair rising edges wait for dead-time underflow
// - each pair has own dead-time enable
// - dead-time registers need timed-access unlock first
// - dead-time only acts in complementary pairing
// - synchronized odd channel copies even partner
// - enable bits 0..2 per pair, bit4 count msb
`default_nettype none
`include "scpwm_consts.svh"

module scpwm_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // ----------------------------------------
  // port pins
  // ----------------------------------------
  input  wire logic [5:0]  gpio_pri_i,
  input  wire logic [3:0]  gpio_alt_i,
  output logic [5:0]       pin_pri_o,
  output logic [5:0]       pin_pri_pwm_o,
  output logic [3:0]       pin_alt_o,
  output logic [3:0]       pin_alt_pwm_o
);

  // ----------------------------------------
  // decoding used in several places
  // ----------------------------------------

  // hit flag: the index is a duty byte register
  function automatic logic duty_hit(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - `SCPWM_IDX_DUTY_BASE;
    duty_hit = idx >= `SCPWM_IDX_DUTY_BASE && off < 8'h0c;
  endfunction

  // channel number of a duty byte register
  function automatic logic [2:0] duty_ch(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - `SCPWM_IDX_DUTY_BASE;
    duty_ch = off[3:1];
  endfunction

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0]  pri_q, pri_d;        // primary route
  logic [7:0]  alt_q, alt_d;        // alternate route
  logic [7:0]  ctrl_q, ctrl_d;      // control one
  logic [7:0]  dten_q, dten_d;      // dead-time enable
  logic [7:0]  dtcnt_q, dtcnt_d;    // dead-time count low
  logic [15:0] per_q, per_d;        // written period
  logic [15:0] duty_q [6];          // written duties
  logic [15:0] duty_d [6];
  logic [15:0] dact_q [6];          // active duties
  logic [15:0] dact_d [6];
  logic [5:0]  raw_q, raw_d;        // raw channel signals
  logic [5:0]  pri_pin_q, pri_pin_d; // primary pin levels
  logic [3:0]  alt_pin_q, alt_pin_d; // alternate pin levels
  scpwm_pkg::scpwm_grd_t grd_q, grd_d; // unlock progress
  logic        ack_q;               // bus answer
  logic [31:0] dat_q, dat_d;        // read data

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [7:0] idx;        // register index
  logic       req;        // request present
  logic       wr;         // write takes effect
  logic [7:0] wb;         // write byte
  logic       open;       // protected write allowed

  always_comb begin
    idx  = adr_i[9:2];
    req  = cyc_i & stb_i;
    // writes land on the edge where ack is seen high
    wr   = req & we_i & ack_q & sel_i[0];
    wb   = dat_i[7:0];
    open = grd_q == scpwm_pkg::SCPWM_GRD_OPEN;
  end

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  scpwm_pkg::scpwm_cfg_t cfg;  // counter form and divider
  scpwm_pkg::scpwm_tb_t  tb;   // counter state

  always_comb begin
    cfg.center = ctrl_q[`SCPWM_CTRL_TYP_BIT];
    cfg.div    = ctrl_q[2:0];
  end

  scpwm_timebase u_timebase (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cfg_i    (cfg),
    .period_i (per_q),
    .tb_o     (tb)
  );

  // ----------------------------------------
  // unlock sequence
  // ----------------------------------------

  // two keys in a row open one protected write
  always_comb begin
    grd_d = grd_q;
    if (wr) begin
      case (grd_q)
        scpwm_pkg::SCPWM_GRD_IDLE: begin
          if (idx == `SCPWM_IDX_GUARD && wb == `SCPWM_KEY_FIRST) begin
            grd_d = scpwm_pkg::SCPWM_GRD_HALF;
          end
        end
        scpwm_pkg::SCPWM_GRD_HALF: begin
          if (idx == `SCPWM_IDX_GUARD && wb == `SCPWM_KEY_SECOND) begin
            grd_d = scpwm_pkg::SCPWM_GRD_OPEN;
          end else begin
            grd_d = scpwm_pkg::SCPWM_GRD_IDLE;
          end
        end
        // any following write uses up the unlock
        default: begin
          grd_d = scpwm_pkg::SCPWM_GRD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_comb begin
    pri_d   = pri_q;
    alt_d   = alt_q;
    ctrl_d  = ctrl_q;
    dten_d  = dten_q;
    dtcnt_d = dtcnt_q;
    per_d   = per_q;
    for (int i = 0; i < 6; i++) begin
      duty_d[i] = duty_q[i];
    end
    if (wr) begin
      case (idx)
        `SCPWM_IDX_ROUTE_PRI: pri_d  = wb & `SCPWM_PRI_MASK;
        `SCPWM_IDX_ROUTE_ALT: alt_d  = wb & `SCPWM_ALT_MASK;
        `SCPWM_IDX_CTRL1:     ctrl_d = wb;
        `SCPWM_IDX_PER_L:     per_d[7:0]  = wb;
        `SCPWM_IDX_PER_H:     per_d[15:8] = wb;
        // protected: dropped silently unless unlocked
        `SCPWM_IDX_DT_EN: begin
          if (open) begin
            dten_d = wb & `SCPWM_DTEN_MASK;
          end
        end
        `SCPWM_IDX_DT_CNT: begin
          if (open) begin
            dtcnt_d = wb;
          end
        end
        default: begin
          if (duty_hit(idx)) begin
            if (idx[0]) begin
              duty_d[duty_ch(idx)][15:8] = wb;
            end else begin
              duty_d[duty_ch(idx)][7:0] = wb;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data and answer
  // ----------------------------------------

  // unmapped indices answer with zero
  always_comb begin
    dat_d = 32'h0000_0000;
    case (idx)
      `SCPWM_IDX_ROUTE_PRI: dat_d[7:0] = pri_q;
      `SCPWM_IDX_ROUTE_ALT: dat_d[7:0] = alt_q;
      `SCPWM_IDX_CTRL1:     dat_d[7:0] = ctrl_q;
      `SCPWM_IDX_DT_EN:     dat_d[7:0] = dten_q;
      `SCPWM_IDX_DT_CNT:    dat_d[7:0] = dtcnt_q;
      `SCPWM_IDX_PER_L:     dat_d[7:0] = per_q[7:0];
      `SCPWM_IDX_PER_H:     dat_d[7:0] = per_q[15:8];
      `SCPWM_IDX_CNT_L:     dat_d[7:0] = tb.cnt[7:0];
      `SCPWM_IDX_CNT_H:     dat_d[7:0] = tb.cnt[15:8];
      // raw signals, direction and unlock state
      `SCPWM_IDX_STAT: dat_d[7:0] = {open, tb.up, raw_q};
      default: begin
        if (duty_hit(idx)) begin
          dat_d[7:0] = idx[0] ? duty_q[duty_ch(idx)][15:8]
                              : duty_q[duty_ch(idx)][7:0];
        end
      end
    endcase
  end

  // ----------------------------------------
  // compare stage
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      // duties follow the period boundary
      dact_d[i] = tb.wrap ? duty_q[i] : dact_q[i];
      raw_d[i]  = raw_q[i];
      if (tb.tick) begin
        if (!cfg.center) begin
          // match wins over the zero set at duty zero
          if (tb.cnt == dact_q[i]) begin
            raw_d[i] = 1'b0;
          end else if (tb.cnt == 16'h0000) begin
            raw_d[i] = 1'b1;
          end
        end else if (tb.cnt == dact_q[i]) begin
          raw_d[i] = ~tb.up;
        end
      end
    end
  end

  // ----------------------------------------
  // pairing and dead time
  // ----------------------------------------
  scpwm_pkg::scpwm_pair_t pair; // selected pairing
  logic [5:0] paired;           // after pairing
  logic [5:0] shaped;           // after dead time
  logic       comp;             // complementary active

  always_comb begin
    pair = scpwm_pkg::scpwm_pair_t'(ctrl_q[`SCPWM_CTRL_MODE_LSB +: 2]);
    comp = pair == scpwm_pkg::SCPWM_PAIR_COMP;
    for (int p = 0; p < 3; p++) begin
      paired[2*p] = raw_q[2*p];
      case (pair)
        scpwm_pkg::SCPWM_PAIR_COMP: begin
          paired[2*p+1] = ~raw_q[2*p];
        end
        scpwm_pkg::SCPWM_PAIR_SYNC: begin
          paired[2*p+1] = raw_q[2*p];
        end
        // reserved code behaves as independent
        default: begin
          paired[2*p+1] = raw_q[2*p+1];
        end
      endcase
    end
  end

  // one identical stage per pair
  for (genvar p = 0; p < 3; p++) begin : g_pair
    scpwm_deadtime u_deadtime (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (tb.tick),
      .en_i   (comp & dten_q[p]),
      .dt_i   ({dten_q[`SCPWM_DTEN_CNT8_BIT], dtcnt_q}),
      .a_i    (paired[2*p]),
      .b_i    (paired[2*p+1]),
      .a_o    (shaped[2*p]),
      .b_o    (shaped[2*p+1])
    );
  end

  // ----------------------------------------
  // pin routing
  // ----------------------------------------

  // registered so pins never glitch on decode
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pri_pin_d[i] = pri_q[i] ? shaped[i] : gpio_pri_i[i];
    end
    // alternate pins carry channels 1, 2, 3 and 5
    alt_pin_d[0] = alt_q[1] ? shaped[1] : gpio_alt_i[0];
    alt_pin_d[1] = alt_q[2] ? shaped[2] : gpio_alt_i[1];
    alt_pin_d[2] = alt_q[3] ? shaped[3] : gpio_alt_i[2];
    alt_pin_d[3] = alt_q[5] ? shaped[5] : gpio_alt_i[3];
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pri_q     <= `SCPWM_RST_BYTE;
      alt_q     <= `SCPWM_RST_BYTE;
      ctrl_q    <= `SCPWM_RST_BYTE;
      dten_q    <= `SCPWM_RST_BYTE;
      dtcnt_q   <= `SCPWM_RST_BYTE;
      per_q     <= 16'h0000;
      raw_q     <= 6'h00;
      pri_pin_q <= 6'h00;
      alt_pin_q <= 4'h0;
      grd_q     <= scpwm_pkg::SCPWM_GRD_IDLE;
      ack_q     <= 1'b0;
      dat_q     <= 32'h0000_0000;
      for (int i = 0; i < 6; i++) begin
        duty_q[i] <= 16'h0000;
        dact_q[i] <= 16'h0000;
      end
    end else begin
      pri_q     <= pri_d;
      alt_q     <= alt_d;
      ctrl_q    <= ctrl_d;
      dten_q    <= dten_d;
      dtcnt_q   <= dtcnt_d;
      per_q     <= per_d;
      raw_q     <= raw_d;
      pri_pin_q <= pri_pin_d;
      alt_pin_q <= alt_pin_d;
      grd_q     <= grd_d;
      // one-cycle answer, dropped the cycle after
      ack_q     <= req & ~ack_q;
      dat_q     <= (req & ~ack_q) ? dat_d : dat_q;
      for (int i = 0; i < 6; i++) begin
        duty_q[i] <= duty_d[i];
        dact_q[i] <= dact_d[i];
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ack_o         = ack_q;
  assign dat_o         = dat_q;
  assign pin_pri_o     = pri_pin_q;
  assign pin_pri_pwm_o = pri_q[5:0];
  assign pin_alt_o     = alt_pin_q;
  assign pin_alt_pwm_o = {alt_q[5], alt_q[3:1]};

endmodule

`default_nettype wire

// ---- scpwm_checker.sv ----
// checker: bus handshake, pin routing and reset of the pwm unit
// assumes a bind onto scpwm_top, one clock and a sync reset
`default_nettype none
`include "scpwm_consts.svh"

module scpwm_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [5:0]  gpio_pri_i,
  input wire logic [3:0]  gpio_alt_i,
  input wire logic [5:0]  pin_pri_o,
  input wire logic [5:0]  pin_pri_pwm_o,
  input wire logic [3:0]  pin_alt_o,
  input wire logic [3:0]  pin_alt_pwm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // accepted route writes and their values
  // ----------------------------------------
  logic       wr_pri;  // primary route write accepted
  logic       wr_alt;  // alternate route write accepted
  logic [5:0] pri_q;   // last primary route written
  logic [5:0] pri_d;
  logic [3:0] alt_q;   // last alternate route, pin order
  logic [3:0] alt_d;
  assign wr_pri = cyc_i && stb_i && we_i && ack_o && sel_i[0]
                  && adr_i[9:2] == `SCPWM_IDX_ROUTE_PRI;
  assign wr_alt = cyc_i && stb_i && we_i && ack_o && sel_i[0]
                  && adr_i[9:2] == `SCPWM_IDX_ROUTE_ALT;

  // next values: hold unless a write lands
  always_comb begin
    pri_d = wr_pri ? dat_i[5:0] : pri_q;
    alt_d = wr_alt ? {dat_i[5], dat_i[3:1]} : alt_q;
  end

  // register only
  always_ff @(posedge clk_i) begin
    pri_q <= rst_i ? 6'h00 : pri_d;
    alt_q <= rst_i ? 4'h0 : alt_d;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_ACK_NEXT:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after a request");
  AST_ACK_PULSE:
    assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE:
    assert property ($rose(ack_o) |-> $past(stb_i))
    else $error("ack without a request");
  AST_DAT_UPPER:
    assert property (dat_o[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  AST_DAT_HOLD:
    assert property (!cyc_i && !ack_o |=> $stable(dat_o))
    else $error("read data moved without a request");
  AST_PRI_GPIO:
    assert property (!$past(rst_i) |->
      ((pin_pri_o ^ $past(gpio_pri_i)) & ~$past(pin_pri_pwm_o)) == 6'h00)
    else $error("primary port pin does not follow its port level");
  AST_ALT_GPIO:
    assert property (!$past(rst_i) |->
      ((pin_alt_o ^ $past(gpio_alt_i)) & ~$past(pin_alt_pwm_o)) == 4'h0)
    else $error("alternate port pin does not follow its port level");
  AST_PRI_ROUTE:
    assert property (wr_pri |=> ##1 pin_pri_pwm_o == pri_q)
    else $error("primary route select not applied");
  AST_ALT_ROUTE:
    assert property (wr_alt |=> ##1 pin_alt_pwm_o == alt_q)
    else $error("alternate route select not applied");
  AST_RST_QUIET:
    assert property (disable iff (1'b0) rst_i |=> !ack_o
      && pin_pri_pwm_o == 6'h00 && pin_alt_pwm_o == 4'h0)
    else $error("outputs not cleared by reset");
endmodule

`default_nettype wire

// ---- scpwm_bridge.sv ----
// half-bridge model: one upper and one lower switch gate
// assumes gates come from the unit's pins, one clock domain
`default_nettype none

module scpwm_bridge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic hi_i,        // upper switch gate
  input  wire logic lo_i,        // lower switch gate
  output logic [5:0] gpio_pri_o, // port levels, primary pins
  output logic [3:0] gpio_alt_o, // port levels, alternate pins
  output logic       shoot_o     // both switches on at once
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] pat_q; // port pattern, every bit keeps moving
  logic [9:0] pat_d;

  // odd step so the low bit flips each cycle
  always_comb begin
    pat_d = pat_q + 10'h157;
  end

  // register only
  always_ff @(posedge clk_i) begin
    pat_q <= rst_i ? 10'h2a5 : pat_d;
  end

  assign gpio_pri_o = pat_q[5:0];
  assign gpio_alt_o = pat_q[9:6];
  // a real bridge would short here: flag it for the bench
  assign shoot_o    = hi_i & lo_i;
endmodule

`default_nettype wire

// ---- scpwm_bench.sv ----
// top testbench: wishbone tasks, register and waveform checks
// assumes scpwm_top, its checker and the bridge model compiled
`default_nettype none
`include "scpwm_consts.svh"

module scpwm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, shoot;
  logic [9:0]  adr_i;
  logic [3:0]  sel_i, gpio_alt, pin_alt, pin_alt_pwm;
  logic [31:0] dat_i, dat_o, rd;
  logic [5:0]  gpio_pri, pin_pri, pin_pri_pwm;
  int          errors, n_tests, hi0, hi1, rise0, both;
  int          cycles = 0;
  logic [7:0]  idx_t[5] = '{8'hc6, 8'hde, 8'hdf, 8'hf9, 8'hfa};
  logic [7:0]  msk_t[5] = '{8'h2e, 8'h3f, 8'hff, 8'h17, 8'hff};
  int          pm[7] = '{0, 1, 2, 3, 1, 1, 2};
  int          pd[7] = '{0, 0, 0, 0, 1, 2, 1};
  int          e0[7] = '{12, 12, 12, 12, 4, 12, 12};
  int          e1[7] = '{20, 28, 12, 20, 20, 28, 12};

  scpwm_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .gpio_pri_i(gpio_pri), .gpio_alt_i(gpio_alt), .pin_pri_o(pin_pri),
    .pin_pri_pwm_o(pin_pri_pwm), .pin_alt_o(pin_alt),
    .pin_alt_pwm_o(pin_alt_pwm));
  // ch0 on the primary pin drives the upper gate, ch1 via alt pin
  scpwm_bridge bridge_u (.clk_i(clk_i), .rst_i(rst_i),
    .hi_i(pin_pri[0]), .lo_i(pin_alt[0]), .gpio_pri_o(gpio_pri),
    .gpio_alt_o(gpio_alt), .shoot_o(shoot));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // hang guard, well above the roughly 1100 cycles needed
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] idx, d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    sel_i <= 4'h1;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n = n + 1;
    end
    if (n == 16) begin
      errors = errors + 1;
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // unlock sequence, then the guarded write
  task automatic prot(input logic [7:0] idx, d);
    wb(1'b1, `SCPWM_IDX_GUARD, `SCPWM_KEY_FIRST);
    wb(1'b1, `SCPWM_IDX_GUARD, `SCPWM_KEY_SECOND);
    wb(1'b1, idx, d);
  endtask

  // count pin activity over a window of whole periods
  task automatic measure(input int win);
    logic prev;
    prev = (pin_pri[0] === 1'b1);
    {hi0, hi1, rise0, both} = 128'h0;
    repeat (win) begin
      @(posedge clk_i);
      hi0 += (pin_pri[0] === 1'b1);
      hi1 += (pin_alt[0] === 1'b1);
      rise0 += (pin_pri[0] === 1'b1 && !prev);
      both += (shoot === 1'b1);
      prev = (pin_pri[0] === 1'b1);
    end
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    {rst_i, cyc_i, stb_i, we_i} = 4'h8;
    adr_i = 10'h000;
    sel_i = 4'h0;
    dat_i = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // ----------------------------------------
    // reset values, masks, guarded writes
    // ----------------------------------------
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, idx_t[i], 8'h00);
      check("reset value", rd, 32'h0);
      wb(1'b1, idx_t[i], 8'hff);
      wb(1'b0, idx_t[i], 8'h00);
      check("plain write", rd, (i < 3) ? msk_t[i] : 8'h00);
      prot(idx_t[i], 8'hff);
      wb(1'b0, idx_t[i], 8'h00);
      check("unlocked write", rd, {24'h0, msk_t[i]});
      prot(idx_t[i], (i == 4) ? 8'h02 : 8'h00);
    end
    wb(1'b1, 8'h10, 8'hff);
    wb(1'b0, 8'h10, 8'h00);
    check("unmapped", rd, 32'h0);
    $display("registers done");
    // ----------------------------------------
    // edge form with two prescale settings
    // ----------------------------------------
    wb(1'b1, `SCPWM_IDX_PER_L, 8'h09);
    wb(1'b1, `SCPWM_IDX_DUTY_BASE, 8'h03);
    wb(1'b1, `SCPWM_IDX_DUTY_BASE + 8'h02, 8'h05);
    wb(1'b1, `SCPWM_IDX_ROUTE_PRI, 8'h01);
    wb(1'b1, `SCPWM_IDX_ROUTE_ALT, 8'h02);
    for (int dv = 0; dv < 2; dv++) begin
      wb(1'b1, `SCPWM_IDX_CTRL1, dv[7:0]);
      repeat (30 << dv) @(posedge clk_i);
      measure(40 << dv);
      check("edge high", hi0, 12 << dv);
      check("edge rises", rise0, 4);
      check("edge odd", hi1, 20 << dv);
    end
    $display("edge form done");
    // ----------------------------------------
    // center form
    // ----------------------------------------
    wb(1'b1, `SCPWM_IDX_PER_L, 8'h08);
    wb(1'b1, `SCPWM_IDX_CTRL1, 8'h10);
    repeat (40) @(posedge clk_i);
    measure(64);
    check("center high", hi0, 24);
    check("center rises", rise0, 4);
    check("center odd", hi1, 40);
    $display("center form done");
    // ----------------------------------------
    // pairing modes and dead time
    // ----------------------------------------
    wb(1'b1, `SCPWM_IDX_PER_L, 8'h09);
    for (int i = 0; i < 7; i++) begin
      prot(`SCPWM_IDX_DT_EN, pd[i][7:0]);
      wb(1'b1, `SCPWM_IDX_CTRL1, {pm[i][1:0], 6'h00});
      repeat (30) @(posedge clk_i);
      measure(40);
      check("even channel", hi0, e0[i]);
      check("odd channel", hi1, e1[i]);
      if (pm[i] == 1) begin
        check("overlap", both, 0);
      end
    end
    $display("pairing done");
    test_done();
  end
endmodule

bind scpwm_top scpwm_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .gpio_pri_i(gpio_pri_i), .gpio_alt_i(gpio_alt_i),
  .pin_pri_o(pin_pri_o), .pin_pri_pwm_o(pin_pri_pwm_o),
  .pin_alt_o(pin_alt_o), .pin_alt_pwm_o(pin_alt_pwm_o));

`default_nettype wire
